// *** eac_consts.vh ***
`ifndef EAC_CONSTS_VH
`define EAC_CONSTS_VH
// ***********************************************
// register byte offsets
// ***********************************************
`define EAC_OFS_CTRL        8'h00
`define EAC_OFS_DATA        8'h04
`define EAC_OFS_ADDR        8'h08
`define EAC_OFS_SPM         8'h0c
`define EAC_OFS_STATUS      8'h10
// ***********************************************
// control and self-program register fields
// ***********************************************
`define EAC_BIT_READ        0
`define EAC_BIT_WRITE       1
`define EAC_BIT_ARM         2
`define EAC_BIT_RIE         3
`define EAC_PM_LO           4
`define EAC_PM_HI           5
`define EAC_BIT_SPM         0
`define EAC_BIT_GIE         1
// ***********************************************
// reset values and modes
// ***********************************************
`define EAC_RST_PM          2'h0
`define EAC_RST_DATA        8'h00
`define EAC_RST_ADDR        10'h000
`define EAC_PM_ATOMIC       2'h0
`define EAC_PM_ERASE        2'h1
`define EAC_PM_WRITE        2'h2
`define EAC_PM_RSVD         2'h3
// ***********************************************
// timing
// ***********************************************
`define EAC_ARM_CYCLES      3'd4
`define EAC_WR_HALT         3'd2
`define EAC_RD_HALT         3'd4
`define EAC_PROG_RC_CYCLES  15'd26368
`define EAC_PROG_TIME_US    3300
`endif

// *** eac_down_counter.v ***
`timescale 1ns/1ps
`default_nettype none
// loadable down counter, flags nonzero while running
module eac_down_counter #(
    parameter W = 3
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire         load,
    input  wire [W-1:0] value,
    input  wire         tick,
    output wire         busy
);
    reg [W-1:0] cnt_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= {W{1'b0}};
        end else if (load) begin
            cnt_q <= value;
        end else if (tick && cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end
    assign busy = (cnt_q != {W{1'b0}});
endmodule // eac_down_counter
`default_nettype wire

// *** eac_top.v ***
// Functional notes
// - write strobe while armed starts programming byte at address with data
// - write strobe without prior arm starts nothing
// - no programming while self-program active; software waits for it
// - hardware clears write strobe when programming time elapses
// - write strobe halts cpu for two cycles
// - read strobe loads data register from current address at once
// - read strobe halts cpu for four cycles
// - during programming no reads and address register locked
// - programming time counted on calibrated rc oscillator cycles
// - arm bit self-clears four cycles after being set
// - mode field selects erase/write action, locked while strobe set
// - ready interrupt is level while strobe and self-program clear and both enables set
// - address is ten bits, upper bits read zero
`timescale 1ns/1ps
`default_nettype none
`include "eac_consts.vh"
module eac_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        rc_clk_pin,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire        cpu_halt,
    output wire        ready_irq,
    output reg  [9:0]  nv_mem_addr,
    output reg  [7:0]  nv_mem_wdata,
    output reg  [1:0]  nv_mem_mode,
    output reg         nv_mem_prog,
    input  wire [7:0]  nv_mem_rdata
);
    // ***********************************************
    // state
    // ***********************************************
    reg  [7:0]  aw_q;
    reg         aw_v_q;
    reg  [31:0] w_q;
    reg  [3:0]  ws_q;
    reg         w_v_q;
    reg  [9:0]  nv_address_reg_q;
    reg  [7:0]  nv_data_reg_q;
    reg  [1:0]  prog_mode_q;
    reg         ready_irq_enable_q;
    reg         write_strobe_q;
    reg         self_program_active_q;
    reg         gie_q;
    reg  [14:0] rc_cnt_q;
    reg  [2:0]  rc_sync_q;
    wire        arm_busy;
    wire        halt_busy;
    wire        rc_rise;
    wire        do_wr;
    wire        ctrl_wr;
    wire        arm_set;
    wire        strobe_go;
    wire        read_go;
    wire [7:0]  wb;

    // ***********************************************
    // axi write path: address and data taken in either order
    // ***********************************************
    assign s_axi_awready = !aw_v_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_v_q && !s_axi_bvalid;
    assign do_wr = aw_v_q && w_v_q && !s_axi_bvalid;
    assign wb = w_q[7:0];
    assign ctrl_wr = do_wr && ws_q[0] && aw_q == `EAC_OFS_CTRL;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 8'h00;
            aw_v_q <= 1'b0;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            w_v_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= {s_axi_awaddr[7:2], 2'b00};
                aw_v_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                w_v_q <= 1'b1;
            end
            if (do_wr) begin
                aw_v_q <= 1'b0;
                w_v_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // address writes while busy are refused in the same response
                s_axi_bresp <= (aw_q > `EAC_OFS_STATUS
                                || (aw_q == `EAC_OFS_ADDR && write_strobe_q)) ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ***********************************************
    // rc oscillator pin, two-flop synchroniser then edge
    // ***********************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            rc_sync_q <= 3'h0;
        end else begin
            rc_sync_q <= {rc_sync_q[1:0], rc_clk_pin};
        end
    end
    assign rc_rise = rc_sync_q[1] && !rc_sync_q[2];

    // ***********************************************
    // arm window and cpu halt counters
    // ***********************************************
    assign arm_set = ctrl_wr && wb[`EAC_BIT_ARM] && !wb[`EAC_BIT_WRITE];
    // strobe honoured only inside the arm window and with no flash write
    assign strobe_go = ctrl_wr && wb[`EAC_BIT_WRITE] && arm_busy
                       && !write_strobe_q && !self_program_active_q;
    assign read_go = ctrl_wr && wb[`EAC_BIT_READ] && !write_strobe_q;

    eac_down_counter #(.W(3)) u_arm (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (arm_set || strobe_go),
        .value   (strobe_go ? 3'd0 : `EAC_ARM_CYCLES),
        .tick    (1'b1),
        .busy    (arm_busy)
    );

    eac_down_counter #(.W(3)) u_halt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .load    (strobe_go || read_go),
        .value   (strobe_go ? `EAC_WR_HALT : `EAC_RD_HALT),
        .tick    (1'b1),
        .busy    (halt_busy)
    );
    assign cpu_halt = halt_busy;

    // ***********************************************
    // registers and programming sequencer
    // ***********************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            nv_address_reg_q <= `EAC_RST_ADDR;
            nv_data_reg_q <= `EAC_RST_DATA;
            ready_irq_enable_q <= 1'b0;
            self_program_active_q <= 1'b0;
            gie_q <= 1'b0;
            // a write in flight survives reset, and so does its mode
            if (!write_strobe_q) begin
                prog_mode_q <= `EAC_RST_PM;
            end
        end else begin
            if (ctrl_wr) begin
                ready_irq_enable_q <= wb[`EAC_BIT_RIE];
                if (!write_strobe_q) begin
                    prog_mode_q <= wb[`EAC_PM_HI:`EAC_PM_LO];
                end
            end
            if (do_wr && ws_q[0] && aw_q == `EAC_OFS_DATA) begin
                nv_data_reg_q <= wb;
            end
            if (do_wr && aw_q == `EAC_OFS_ADDR && !write_strobe_q) begin
                if (ws_q[0]) nv_address_reg_q[7:0] <= w_q[7:0];
                if (ws_q[1]) nv_address_reg_q[9:8] <= w_q[9:8];
            end
            if (do_wr && ws_q[0] && aw_q == `EAC_OFS_SPM) begin
                self_program_active_q <= wb[`EAC_BIT_SPM];
                gie_q <= wb[`EAC_BIT_GIE];
            end
            if (read_go) begin
                nv_data_reg_q <= nv_mem_rdata;
            end
        end
    end

    // the sequencer ignores reset while a write runs so the write completes
    // busy is tested first so an unknown power-up strobe falls into reset
    always @(posedge aclk) begin
        if (write_strobe_q) begin
            if (rc_rise) begin
                if (rc_cnt_q == 15'd1) begin
                    write_strobe_q <= 1'b0;
                    nv_mem_prog <= 1'b0;
                    rc_cnt_q <= 15'd0;
                end else begin
                    rc_cnt_q <= rc_cnt_q - 15'd1;
                end
            end
        end else if (!aresetn) begin
            write_strobe_q <= 1'b0;
            rc_cnt_q <= 15'd0;
            nv_mem_prog <= 1'b0;
            nv_mem_addr <= 10'h000;
            nv_mem_wdata <= 8'h00;
            nv_mem_mode <= `EAC_RST_PM;
        end else if (strobe_go) begin
            write_strobe_q <= 1'b1;
            nv_mem_prog <= 1'b1;
            nv_mem_addr <= nv_address_reg_q;
            nv_mem_wdata <= nv_data_reg_q;
            nv_mem_mode <= prog_mode_q;
            rc_cnt_q <= `EAC_PROG_RC_CYCLES;
        end else begin
            // idle: the array follows the address register so a read strobe hits it
            nv_mem_addr <= nv_address_reg_q;
        end
    end

    assign ready_irq = ready_irq_enable_q && gie_q && !write_strobe_q
                       && !self_program_active_q;

    // ***********************************************
    // axi read path
    // ***********************************************
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case ({s_axi_araddr[7:2], 2'b00})
                `EAC_OFS_CTRL: s_axi_rdata <= {26'h0, prog_mode_q,
                    ready_irq_enable_q, arm_busy, write_strobe_q, 1'b0};
                `EAC_OFS_DATA: s_axi_rdata <= {24'h0, nv_data_reg_q};
                `EAC_OFS_ADDR: s_axi_rdata <= {22'h0, nv_address_reg_q};
                `EAC_OFS_SPM: s_axi_rdata <= {30'h0, gie_q, self_program_active_q};
                `EAC_OFS_STATUS: s_axi_rdata <= {30'h0, ready_irq, cpu_halt};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // eac_top
`default_nettype wire

// *** eac_top_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checker
// ****************
module eac_top_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       cpu_halt,
    input wire logic       ready_irq,
    input wire logic [9:0] nv_mem_addr,
    input wire logic       nv_mem_prog
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // a write stalls two cycles, a read four
    sequence s_halt_wr;
        cpu_halt [*2] ##1 !cpu_halt;
    endsequence
    sequence s_halt_rd;
        cpu_halt [*4] ##1 !cpu_halt;
    endsequence
    a_halt_len: assert property ($rose(cpu_halt) |-> s_halt_wr or s_halt_rd)
        else $error("halt pulse length wrong");
    a_halt_prog: assert property ($rose(nv_mem_prog) |-> ##[0:1] cpu_halt)
        else $error("no halt at write start");
    a_prog_long: assert property ($rose(nv_mem_prog) |=> nv_mem_prog [*8])
        else $error("programming ended early");
    a_addr_lock: assert property (nv_mem_prog && $past(nv_mem_prog) |-> $stable(nv_mem_addr))
        else $error("address moved while busy");
    a_irq_quiet: assert property (nv_mem_prog |-> !ready_irq)
        else $error("ready irq while busy");
    a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
endmodule // eac_top_checker
bind eac_top eac_top_checker u_chk (.*);
`default_nettype wire

// *** eac_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "eac_consts.vh"
`define CHK(nm, ex, gt) begin cmp_count++; if ((ex) !== (gt)) begin failures++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
// ****************
// bench for the nonvolatile access block
// ****************
module eac_top_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, rc_clk_pin = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, a, d;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, nv_mem_mode;
    logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    logic        cpu_halt, ready_irq, nv_mem_prog;
    logic [9:0]  nv_mem_addr;
    logic [7:0]  nv_mem_wdata;
    logic [34:0] e;
    logic [34:0] exp_q[$];
    int          failures = 0, cmp_count = 0, rc_n = 0, n = 0;
    // array model: each byte is a fixed function of its address
    wire  [7:0]  nv_mem_rdata = nv_mem_addr[7:0] ^ 8'h5a;
    always #20 aclk = ~aclk;
    // slower than half of aclk so the synchroniser never drops an edge
    always #41 rc_clk_pin = ~rc_clk_pin;
    always @(posedge rc_clk_pin) if (nv_mem_prog) rc_n++;
    eac_top u_eac_top (.*);
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task tick(inout int k);
        @(posedge aclk);
        k++;
        if (k > 70000) begin
            failures++;
            conclude();
        end
    endtask
    task automatic wr(input [7:0] o, input [31:0] v, input [1:0] r = 2'h0);
        int k = 0;
        bit ad = 0;
        bit wd = 0;
        exp_q.push_back({1'b0, r, 32'h0});
        s_axi_awaddr <= {24'h0, o};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            tick(k);
            if (s_axi_awready) ad = 1;
            if (s_axi_wready) wd = 1;
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
        end
        do tick(k); while (!s_axi_bvalid);
    endtask
    task automatic rd(input [7:0] o, input [31:0] x, input [1:0] r = 2'h0);
        int k = 0;
        exp_q.push_back({1'b1, r, x});
        s_axi_araddr <= {24'h0, o};
        s_axi_arvalid <= 1'b1;
        do tick(k); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do tick(k); while (!s_axi_rvalid);
    endtask
    // responses are matched against the oldest note
    always @(posedge aclk) begin
        if (s_axi_bvalid || s_axi_rvalid) begin
            e = exp_q.pop_front();
            if (e[34]) `CHK("rdata", e[31:0], s_axi_rdata)
            `CHK("resp", e[33:32], e[34] ? s_axi_rresp : s_axi_bresp)
        end
    end
    initial begin
        void'($urandom(57363));
        a = $urandom;
        d = $urandom;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`EAC_OFS_CTRL, 32'h0);
        rd(`EAC_OFS_DATA, 32'h0);
        rd(8'h14, 32'h0, 2'h2);
        wr(8'h20, a, 2'h2);
        wr(`EAC_OFS_ADDR, a);
        rd(`EAC_OFS_ADDR, a & 32'h3ff);
        wr(`EAC_OFS_CTRL, 32'h02);
        rd(`EAC_OFS_CTRL, 32'h0);
        wr(`EAC_OFS_CTRL, 32'h04);
        repeat (6) tick(n);
        rd(`EAC_OFS_CTRL, 32'h0);
        wr(`EAC_OFS_CTRL, 32'h02);
        rd(`EAC_OFS_CTRL, 32'h0);
        for (int m = 0; m < 3; m++) begin
            wr(`EAC_OFS_CTRL, m << 4);
            rd(`EAC_OFS_CTRL, m << 4);
        end
        wr(`EAC_OFS_SPM, 32'h3);
        wr(`EAC_OFS_CTRL, 32'h0c);
        wr(`EAC_OFS_CTRL, 32'h0a);
        rd(`EAC_OFS_CTRL, 32'h08);
        rd(`EAC_OFS_STATUS, 32'h0);
        wr(`EAC_OFS_SPM, 32'h2);
        rd(`EAC_OFS_STATUS, 32'h2);
        wr(`EAC_OFS_CTRL, 32'h01);
        rd(`EAC_OFS_DATA, {24'h0, a[7:0] ^ 8'h5a});
        rd(`EAC_OFS_CTRL, 32'h0);
        wr(`EAC_OFS_DATA, d);
        wr(`EAC_OFS_CTRL, 32'h24);
        wr(`EAC_OFS_CTRL, 32'h22);
        repeat (6) tick(n);
        `CHK("addr", a[9:0], nv_mem_addr)
        `CHK("wdata", d[7:0], nv_mem_wdata)
        `CHK("mode", 2'h2, nv_mem_mode)
        rd(`EAC_OFS_CTRL, 32'h22);
        wr(`EAC_OFS_ADDR, 32'h0, 2'h2);
        wr(`EAC_OFS_CTRL, 32'h13);
        rd(`EAC_OFS_DATA, {24'h0, d[7:0]});
        rd(`EAC_OFS_CTRL, 32'h22);
        n = 0;
        while (nv_mem_prog) tick(n);
        `CHK("rc edges", 1'b1, rc_n > 26365 && rc_n < 26371)
        rd(`EAC_OFS_CTRL, 32'h20);
        wr(`EAC_OFS_CTRL, 32'h01);
        rd(`EAC_OFS_DATA, {24'h0, a[7:0] ^ 8'h5a});
        conclude();
    end
endmodule // eac_top_tb
`default_nettype wire
